// ---- tmr01_timer.sv ----
// Purpose: timer 0 and timer 1 with clock control register
// Assumes: special-register port as in the core, one-cycle wr and rd
// Notes:   event and gate pins pass two flip-flops before use
`timescale 1ns/1ps
module tmr01_timer
    import tmr01_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  tmr01_pkg::tmr01_sfr_t sfr,
    input  wire logic       tmr0_event_pin,
    input  wire logic       tmr1_event_pin,
    input  wire logic       ext_irq0_input,
    input  wire logic       ext_irq1_input,
    input  wire logic       ext_osc_clk,
    input  wire logic       tmr0_irq_enable,
    input  wire logic       tmr1_irq_enable,
    input  wire logic       tmr0_vector_ack,
    input  wire logic       tmr1_vector_ack,
    output logic [7:0]      rdata,
    output logic            tmr0_irq,
    output logic            tmr1_irq,
    output logic            tmr1_overflow_pulse,
    output logic            timer2_low_clk_sel,
    output logic            timer2_high_clk_sel,
    output logic            timer3_low_clk_sel,
    output logic            timer3_high_clk_sel
);
    import tmr01_pkg::*;

    // ----------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic [1:0] evt_prev;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 5'h1F;
            pin_sync <= 5'h1F;
            evt_prev <= 2'h3;
        end else begin
            pin_meta <= {ext_osc_clk, ext_irq1_input, ext_irq0_input, tmr1_event_pin, tmr0_event_pin};
            pin_sync <= pin_meta;
            evt_prev <= pin_sync[1:0];
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0]  timer_clock_select;
    logic [7:0]  timer_mode_select;
    logic [7:0]  ext_irq_config;
    logic        tmr0_run;
    logic        tmr1_run;
    logic        tmr0_overflow_flag;
    logic        tmr1_overflow_flag;
    logic [7:0]  tmr0_low_byte;
    logic [7:0]  tmr0_high_byte;
    logic [7:0]  tmr1_low_byte;
    logic [7:0]  tmr1_high_byte;
    tmr01_mode_t mode0;
    tmr01_mode_t mode1;

    assign mode0 = timer_mode_select[3:0];
    assign mode1 = timer_mode_select[7:4];

    wire wr_run   = sfr.wr && (sfr.addr == ADDR_RUN_FLAGS);
    wire wr_mode  = sfr.wr && (sfr.addr == ADDR_MODE_SELECT);
    wire wr_t0l   = sfr.wr && (sfr.addr == ADDR_T0_LOW);
    wire wr_t1l   = sfr.wr && (sfr.addr == ADDR_T1_LOW);
    wire wr_t0h   = sfr.wr && (sfr.addr == ADDR_T0_HIGH);
    wire wr_t1h   = sfr.wr && (sfr.addr == ADDR_T1_HIGH);
    wire wr_ck    = sfr.wr && (sfr.addr == ADDR_CLK_SELECT);
    wire wr_cfg   = sfr.wr && (sfr.addr == ADDR_IRQ_CONFIG);

    // ----------------------------------------
    // tick sources
    // ----------------------------------------
    logic pre_tick;

    tmr01_prescaler u_pre (
        .clk      (clk),
        .rst_n    (rst_n),
        .code     (timer_clock_select[1:0]),
        .ext_sync (pin_sync[4]),
        .tick     (pre_tick)
    );

    wire t0_fall = evt_prev[0] & ~pin_sync[0];
    wire t1_fall = evt_prev[1] & ~pin_sync[1];
    wire tmr0_gate_enable_act = ~(pin_sync[2] ^ ext_irq_config[CFG_EXT_IRQ0_POLARITY]);
    wire tmr1_gate_enable_act = ~(pin_sync[3] ^ ext_irq_config[CFG_EXT_IRQ1_POLARITY]);
    wire t0_split = (mode0.mode == MODE_SPLIT);

    // internal clocks: the system clock is a tick every cycle
    wire t0_int = timer_clock_select[CK_T0M] ? 1'b1 : pre_tick;
    wire t1_int = timer_clock_select[CK_T1M] ? 1'b1 : pre_tick;

    wire t0_src = mode0.counter_sel ? t0_fall : t0_int;
    wire t1_src = (mode1.counter_sel && !t0_split) ? t1_fall : t1_int;

    wire t0_en = tmr0_run && (!mode0.gate || tmr0_gate_enable_act);
    wire t1_en_norm = tmr1_run && (!mode1.gate || tmr1_gate_enable_act);
    // in split mode timer 1 run bit belongs to the high byte of timer 0
    wire t1_en = t0_split ? (mode1.mode != MODE_SPLIT) : (t1_en_norm && mode1.mode != MODE_SPLIT);
    wire th0_en = t0_split && tmr1_run;

    wire t0_inc = t0_en && t0_src;
    wire t1_inc = t1_en && t1_src;
    wire th0_inc = th0_en && t0_int;

    // ----------------------------------------
    // count step, shared by both timers
    // ----------------------------------------
    function automatic logic [16:0] step(input logic [1:0] mode, input logic [7:0] lo, input logic [7:0] hi);
        logic [16:0] r;
        r = {1'b0, hi, lo};
        if (mode == MODE_13BIT) begin
            if (lo[4:0] == LOW5_MAX) begin
                r = {(hi == BYTE_MAX), hi + 8'h01, lo[7:5], 5'h00};
            end else begin
                r = {1'b0, hi, lo + 8'h01};
            end
        end else if (mode == MODE_16BIT) begin
            r = {1'b0, hi, lo} + 17'h00001;
        end else begin
            if (lo == BYTE_MAX) begin
                r = {1'b1, hi, hi};
            end else begin
                r = {1'b0, hi, lo + 8'h01};
            end
        end
        return r;
    endfunction

    wire [1:0]  t0_step_mode = t0_split ? MODE_RELOAD : mode0.mode;
    wire [16:0] t0_next = step(t0_step_mode, tmr0_low_byte, t0_split ? 8'h00 : tmr0_high_byte);
    wire [16:0] t1_next = step(mode1.mode, tmr1_low_byte, tmr1_high_byte);
    // split low byte wraps to zero, not to the high byte
    wire [7:0]  t0_low_next = t0_split ? tmr0_low_byte + 8'h01 : t0_next[7:0];
    wire        t0_ovf = t0_inc && t0_next[16];
    wire        th0_ovf = th0_inc && (tmr0_high_byte == BYTE_MAX);
    wire        t1_ovf = t1_inc && t1_next[16];

    // ----------------------------------------
    // count and control state
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr0_low_byte  <= REG_RESET;
            tmr0_high_byte <= REG_RESET;
            tmr1_low_byte  <= REG_RESET;
            tmr1_high_byte <= REG_RESET;
        end else begin
            // a software write wins over a count in the same cycle
            if (wr_t0l) begin
                tmr0_low_byte <= sfr.wdata;
            end else if (t0_inc) begin
                tmr0_low_byte <= t0_low_next;
            end
            if (wr_t0h) begin
                tmr0_high_byte <= sfr.wdata;
            end else if (th0_inc) begin
                tmr0_high_byte <= tmr0_high_byte + 8'h01;
            end else if (t0_inc && !t0_split) begin
                tmr0_high_byte <= t0_next[15:8];
            end
            if (wr_t1l) begin
                tmr1_low_byte <= sfr.wdata;
            end else if (t1_inc) begin
                tmr1_low_byte <= t1_next[7:0];
            end
            if (wr_t1h) begin
                tmr1_high_byte <= sfr.wdata;
            end else if (t1_inc) begin
                tmr1_high_byte <= t1_next[15:8];
            end
        end
    end

    wire set_tf0 = t0_ovf;
    wire set_tf1 = t0_split ? th0_ovf : t1_ovf;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr0_run           <= 1'b0;
            tmr1_run           <= 1'b0;
            tmr0_overflow_flag <= 1'b0;
            tmr1_overflow_flag <= 1'b0;
        end else begin
            // run bits only gate counting, the count is left alone
            if (wr_run) begin
                tmr0_run <= sfr.wdata[RUN_TR0];
                tmr1_run <= sfr.wdata[RUN_TR1];
            end
            // hardware set wins over a clear in the same cycle
            if (set_tf0) begin
                tmr0_overflow_flag <= 1'b1;
            end else if (tmr0_vector_ack) begin
                tmr0_overflow_flag <= 1'b0;
            end else if (wr_run) begin
                tmr0_overflow_flag <= sfr.wdata[RUN_TF0];
            end
            if (set_tf1) begin
                tmr1_overflow_flag <= 1'b1;
            end else if (tmr1_vector_ack) begin
                tmr1_overflow_flag <= 1'b0;
            end else if (wr_run) begin
                tmr1_overflow_flag <= sfr.wdata[RUN_TF1];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_clock_select <= REG_RESET;
            timer_mode_select  <= REG_RESET;
            ext_irq_config     <= REG_RESET;
        end else begin
            if (wr_ck) begin
                timer_clock_select <= sfr.wdata;
            end
            if (wr_mode) begin
                timer_mode_select <= sfr.wdata;
            end
            if (wr_cfg) begin
                ext_irq_config <= sfr.wdata;
            end
        end
    end

    // ----------------------------------------
    // read data and outputs
    // ----------------------------------------
    logic [7:0] next_rdata;
    wire [7:0] run_view = {tmr1_overflow_flag, tmr1_run, tmr0_overflow_flag, tmr0_run, 4'h0};

    assign next_rdata = (sfr.addr == ADDR_RUN_FLAGS)   ? run_view :
                        (sfr.addr == ADDR_MODE_SELECT) ? timer_mode_select :
                        (sfr.addr == ADDR_T0_LOW)      ? tmr0_low_byte :
                        (sfr.addr == ADDR_T1_LOW)      ? tmr1_low_byte :
                        (sfr.addr == ADDR_T0_HIGH)     ? tmr0_high_byte :
                        (sfr.addr == ADDR_T1_HIGH)     ? tmr1_high_byte :
                        (sfr.addr == ADDR_CLK_SELECT)  ? timer_clock_select :
                        (sfr.addr == ADDR_IRQ_CONFIG)  ? ext_irq_config : 8'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata               <= 8'h00;
            tmr0_irq            <= 1'b0;
            tmr1_irq            <= 1'b0;
            tmr1_overflow_pulse <= 1'b0;
            timer2_low_clk_sel  <= 1'b0;
            timer2_high_clk_sel <= 1'b0;
            timer3_low_clk_sel  <= 1'b0;
            timer3_high_clk_sel <= 1'b0;
        end else begin
            rdata               <= sfr.rd ? next_rdata : 8'h00;
            tmr0_irq            <= tmr0_overflow_flag && tmr0_irq_enable;
            tmr1_irq            <= tmr1_overflow_flag && tmr1_irq_enable;
            tmr1_overflow_pulse <= t1_ovf;
            timer2_low_clk_sel  <= timer_clock_select[4];
            timer2_high_clk_sel <= timer_clock_select[5];
            timer3_low_clk_sel  <= timer_clock_select[6];
            timer3_high_clk_sel <= timer_clock_select[7];
        end
    end
endmodule

// ---- tmr01_pkg.sv ----
// Purpose: constants and types for the timer 0/1 block
// Assumes: 8-bit special-register port, one system clock
// Notes:   offsets are the register addresses on the special-register port
package tmr01_pkg;
    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_RUN_FLAGS   = 8'h88;
    localparam logic [7:0] ADDR_MODE_SELECT = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW      = 8'h8A;
    localparam logic [7:0] ADDR_T1_LOW      = 8'h8B;
    localparam logic [7:0] ADDR_T0_HIGH     = 8'h8C;
    localparam logic [7:0] ADDR_T1_HIGH     = 8'h8D;
    localparam logic [7:0] ADDR_CLK_SELECT  = 8'h8E;
    localparam logic [7:0] ADDR_IRQ_CONFIG  = 8'hE4;
    localparam logic [7:0] REG_RESET        = 8'h00;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int RUN_TF1 = 7;
    localparam int RUN_TR1 = 6;
    localparam int RUN_TF0 = 5;
    localparam int RUN_TR0 = 4;
    localparam int CK_T1M  = 3;
    localparam int CK_T0M  = 2;
    localparam int CFG_EXT_IRQ1_POLARITY = 7;
    localparam int CFG_EXT_IRQ0_POLARITY = 3;

    // ----------------------------------------
    // prescale codes and divisors
    // ----------------------------------------
    localparam logic [1:0] PRE_DIV12 = 2'h0;
    localparam logic [1:0] PRE_DIV4  = 2'h1;
    localparam logic [1:0] PRE_DIV48 = 2'h2;
    localparam logic [1:0] PRE_EXT8  = 2'h3;
    localparam int DIV12 = 12;
    localparam int DIV4  = 4;
    localparam int DIV48 = 48;
    localparam int EXT_DIV = 8;

    // ----------------------------------------
    // timer modes and count limits
    // ----------------------------------------
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam logic [4:0] LOW5_MAX = 5'h1F;
    localparam logic [7:0] BYTE_MAX = 8'hFF;

    typedef struct packed {
        logic       gate;
        logic       counter_sel;
        logic [1:0] mode;
    } tmr01_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tmr01_sfr_t;
endpackage

// ---- tmr01_prescaler.sv ----
// Purpose: shared prescaled tick for timers 0 and 1
// Assumes: ext_osc_clk already synchronised to clk by the caller
// Notes:   emits a one-cycle tick, never a derived clock
`timescale 1ns/1ps
module tmr01_prescaler
    import tmr01_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] code,
    input  wire logic       ext_sync,
    output logic            tick
);
    logic [5:0] div_count;
    logic [2:0] ext_count;
    logic       ext_prev;
    logic [5:0] limit;
    logic       ext_fall;
    logic       ext_tick;

    assign limit = (code == PRE_DIV4)  ? 6'(DIV4 - 1) :
                   (code == PRE_DIV48) ? 6'(DIV48 - 1) : 6'(DIV12 - 1);
    assign ext_fall = ext_prev & ~ext_sync;
    assign ext_tick = ext_fall && (ext_count == 3'(EXT_DIV - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_count <= 6'h00;
            ext_count <= 3'h0;
            ext_prev  <= 1'b0;
            tick      <= 1'b0;
        end else begin
            ext_prev  <= ext_sync;
            div_count <= (div_count >= limit) ? 6'h00 : div_count + 6'h01;
            if (ext_fall) begin
                ext_count <= ext_count + 3'h1;
            end
            tick <= (code == PRE_EXT8) ? ext_tick : (div_count >= limit);
        end
    end
endmodule

// ---- tmr01_timer_chk.sv ----
// Purpose: port-level checks for the timer 0/1 block
// Assumes: one clock domain, rstn active low
// Notes:   sees only top-level ports; attached by bind at the foot
`timescale 1ns/1ps
module tmr01_timer_chk
    import tmr01_pkg::*;
(
    input wire logic             clk,
    input wire logic             rstn,
    input tmr01_pkg::tmr01_sfr_t sfr,
    input wire logic             tmr0_irq_enable,
    input wire logic             tmr1_irq_enable,
    input wire logic             tmr0_vector_ack,
    input wire logic [7:0]       rdata,
    input wire logic             tmr0_irq,
    input wire logic             tmr1_irq,
    input wire logic             tmr1_overflow_pulse,
    input wire logic             timer2_low_clk_sel,
    input wire logic             timer2_high_clk_sel,
    input wire logic             timer3_low_clk_sel,
    input wire logic             timer3_high_clk_sel
);
    logic       ck_wr;
    logic       mapped;
    logic [3:0] sels;
    assign ck_wr  = sfr.wr && (sfr.addr == ADDR_CLK_SELECT);
    assign mapped = (sfr.addr inside {[ADDR_RUN_FLAGS:ADDR_CLK_SELECT], ADDR_IRQ_CONFIG});
    assign sels   = {timer3_high_clk_sel, timer3_low_clk_sel, timer2_high_clk_sel, timer2_low_clk_sel};

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_rd_idle; !sfr.rd |=> rdata == 8'h00; endproperty
    property p_unmapped; sfr.rd && !mapped |=> rdata == 8'h00; endproperty
    // copies may lag the register by one edge, so look two edges on
    property p_sel_write; ck_wr ##1 !ck_wr |=> sels == $past(sfr.wdata[7:4], 2); endproperty
    property p_sel_hold; !$past(ck_wr) && !$past(ck_wr, 2) |-> $stable(sels); endproperty
    property p_irq0_mask; !$past(tmr0_irq_enable) |-> !tmr0_irq; endproperty
    property p_irq1_mask; !$past(tmr1_irq_enable) |-> !tmr1_irq; endproperty
    property p_vec_clear; tmr0_vector_ack |-> ##2 !tmr0_irq; endproperty
    property p_reset_quiet;
        disable iff (1'b0) !rstn |=> !tmr0_irq && !tmr1_irq && !tmr1_overflow_pulse && rdata == 8'h00 && sels == 4'h0;
    endproperty

    a_rd_idle:     assert property (p_rd_idle) else $error("read data not zero without a read");
    a_unmapped:    assert property (p_unmapped) else $error("unmapped read not zero");
    a_sel_write:   assert property (p_sel_write) else $error("clock select outputs miss write");
    a_sel_hold:    assert property (p_sel_hold) else $error("clock select outputs moved alone");
    a_irq0_mask:   assert property (p_irq0_mask) else $error("timer 0 irq while disabled");
    a_irq1_mask:   assert property (p_irq1_mask) else $error("timer 1 irq while disabled");
    a_vec_clear:   assert property (p_vec_clear) else $error("timer 0 irq held after vector");
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");

    c_irq0:   cover property (tmr0_irq);
    c_ovf1:   cover property (tmr1_overflow_pulse);
    c_ck_wr:  cover property (ck_wr ##1 !ck_wr);
endmodule

bind tmr01_timer tmr01_timer_chk u_chk (.clk(clk), .rstn(rstn), .sfr(sfr), .tmr0_irq_enable(tmr0_irq_enable),
    .tmr1_irq_enable(tmr1_irq_enable), .tmr0_vector_ack(tmr0_vector_ack), .rdata(rdata), .tmr0_irq(tmr0_irq),
    .tmr1_irq(tmr1_irq), .tmr1_overflow_pulse(tmr1_overflow_pulse), .timer2_low_clk_sel(timer2_low_clk_sel),
    .timer2_high_clk_sel(timer2_high_clk_sel), .timer3_low_clk_sel(timer3_low_clk_sel),
    .timer3_high_clk_sel(timer3_high_clk_sel));

// ---- tmr01_pins_model.sv ----
// Purpose: external event, gate and oscillator pins
// Assumes: bench asks for event bursts and gate levels
// Notes:   oscillator free-runs, unrelated in phase to clk
`timescale 1ns/1ps
module tmr01_pins_model (
    input  wire logic       clk,
    input  wire logic [1:0] ev_go,
    input  wire logic [1:0] gate_lvl,
    output logic [1:0]      ev_pins,
    output logic [1:0]      gate_pins,
    output logic            osc
);
    logic [1:0] hold;
    initial begin
        ev_pins = 2'b11;
        hold = 2'd0;
        osc = 1'b0;
    end
    // ----------------------------------------
    // event pins
    // ----------------------------------------
    // three clocks per level, above the two-clock minimum
    always @(posedge clk) begin
        hold <= (hold == 2'd2) ? 2'd0 : hold + 2'd1;
        if (hold == 2'd2)
            ev_pins <= ev_pins ^ ev_go;
    end
    assign gate_pins = gate_lvl;
    // well below a quarter of clk, so every edge is seen
    always #197 osc = ~osc;
endmodule

// ---- tmr01_timer_test.sv ----
// Purpose: self-checking bench for the timer 0/1 block
// Assumes: register port driven 1 ns after each rising edge
// Notes:   counts worked out from edge arithmetic, never read back first
`timescale 1ns/1ps
module tmr01_timer_test;
    import tmr01_pkg::*;
    logic       clk, rstn, irq_en, ack, osc, irq0, irq1, ovf1;
    tmr01_sfr_t sfr;
    logic [1:0] ev_go, gate_lvl, ev_pins, gate_pins;
    logic [7:0] rdata, got;
    logic [3:0] sels;
    int         fails, tests_run, cycles, ovf_seen;
    int         falls [2];
    logic [7:0] regs [8] = '{ADDR_RUN_FLAGS, ADDR_MODE_SELECT, ADDR_T0_LOW, ADDR_T1_LOW, ADDR_T0_HIGH,
                             ADDR_T1_HIGH, ADDR_CLK_SELECT, ADDR_IRQ_CONFIG};
    // mode, low, high, expected low, expected high, low mask
    logic [7:0] mt [3][6] = '{'{8'h00, 8'h1E, 8'hFF, 8'h06, 8'h00, 8'h1F},
                              '{8'h01, 8'hFE, 8'hFF, 8'h06, 8'h00, 8'hFF},
                              '{8'h02, 8'hFE, 8'h80, 8'h86, 8'h80, 8'hFF}};
    logic [7:0] dv [4] = '{8'd20, 8'd60, 8'd5, 8'd3};
    // mode, t0 high, t1 high, t1 low, expected flags, expected t0 high, pulses
    logic [7:0] sp [3][7] = '{'{8'h13, 8'h00, 8'hFF, 8'hFE, 8'h40, 8'h06, 8'h01},
                              '{8'h13, 8'hFE, 8'h00, 8'h00, 8'hC0, 8'h04, 8'h00},
                              '{8'h33, 8'h00, 8'h00, 8'h00, 8'h40, 8'h06, 8'h00}};

    tmr01_pins_model u_pins (.clk(clk), .ev_go(ev_go), .gate_lvl(gate_lvl), .ev_pins(ev_pins),
        .gate_pins(gate_pins), .osc(osc));
    tmr01_timer u_dut (.clk(clk), .rstn(rstn), .sfr(sfr), .tmr0_event_pin(ev_pins[0]),
        .tmr1_event_pin(ev_pins[1]), .ext_irq0_input(gate_pins[0]), .ext_irq1_input(gate_pins[1]),
        .ext_osc_clk(osc), .tmr0_irq_enable(irq_en), .tmr1_irq_enable(irq_en), .tmr0_vector_ack(ack),
        .tmr1_vector_ack(ack), .rdata(rdata), .tmr0_irq(irq0), .tmr1_irq(irq1), .tmr1_overflow_pulse(ovf1),
        .timer2_low_clk_sel(sels[0]), .timer2_high_clk_sel(sels[1]), .timer3_low_clk_sel(sels[2]),
        .timer3_high_clk_sel(sels[3]));

    always #20 clk = ~clk;
    always @(negedge ev_pins[0]) falls[0]++;
    always @(negedge ev_pins[1]) falls[1]++;
    always @(posedge clk) if (ovf1 === 1'b1) ovf_seen++;

    // ----------------------------------------
    // register port tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 sfr = '{1'b1, 1'b0, a, d};
        @(posedge clk);
        #1 sfr.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        #1 sfr = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        #1 sfr.rd = 1'b0;
        got = rdata;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic setup(input logic [7:0] md, input logic [7:0] ck, input int t, input logic [7:0] lo,
                         input logic [7:0] hi);
        wr(ADDR_MODE_SELECT, md);
        wr(ADDR_CLK_SELECT, ck);
        wr(t ? ADDR_T1_LOW : ADDR_T0_LOW, lo);
        wr(t ? ADDR_T1_HIGH : ADDR_T0_HIGH, hi);
    endtask
    task automatic close_out;
        $display("mismatches=%0d comparisons=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // generous ceiling: the sequence needs about 1500 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        sfr = '0;
        irq_en = 1'b0;
        ack = 1'b0;
        ev_go = 2'b00;
        gate_lvl = 2'b00;
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk);
        foreach (regs[i]) begin
            rd(regs[i]);
            chk(got, REG_RESET);
        end
        wr(8'h90, 8'hA5);
        rd(8'h90);
        chk(got, 8'h00);
        wr(ADDR_CLK_SELECT, 8'hF3);
        rd(ADDR_CLK_SELECT);
        chk(got, 8'hF3);
        chk({4'h0, sels}, 8'h0F);
        wr(ADDR_T1_HIGH, 8'h5A);
        rd(ADDR_T1_HIGH);
        chk(got, 8'h5A);
        irq_en = 1'b1;
        for (int i = 0; i < 3; i++) begin
            setup(mt[i][0], 8'h04, 0, mt[i][1], mt[i][2]);
            wr(ADDR_RUN_FLAGS, 8'h10);
            repeat (2) @(posedge clk);
            rd(ADDR_RUN_FLAGS);
            chk(got, 8'h30);
            chk({7'h0, irq0}, 8'h01);
            @(posedge clk);
            #1 ack = 1'b1;
            @(posedge clk);
            #1 ack = 1'b0;
            wr(ADDR_RUN_FLAGS, 8'h00);
            rd(ADDR_T0_LOW);
            chk(got & mt[i][5], mt[i][3]);
            rd(ADDR_T0_HIGH);
            chk(got, mt[i][4]);
            chk({7'h0, irq0}, 8'h00);
        end
        irq_en = 1'b0;
        for (int i = 0; i < 4; i++) begin
            setup(8'h01, 8'(i), 0, 8'h00, 8'h00);
            wr(ADDR_RUN_FLAGS, 8'h10);
            repeat (238) @(posedge clk);
            wr(ADDR_RUN_FLAGS, 8'h00);
            rd(ADDR_T0_LOW);
            chk({7'h0, got === dv[i] || got === dv[i] + 8'd1}, 8'h01);
        end
        for (int t = 0; t < 2; t++) begin
            gate_lvl[t] = t[0];
            wr(ADDR_IRQ_CONFIG, 8'h08);
            setup(t ? 8'h90 : 8'h09, 8'h0C, t, 8'h00, 8'h00);
            wr(ADDR_RUN_FLAGS, t ? 8'h40 : 8'h10);
            repeat (20) @(posedge clk);
            rd(t ? ADDR_T1_LOW : ADDR_T0_LOW);
            chk(got, 8'h00);
            gate_lvl[t] = ~t[0];
            repeat (20) @(posedge clk);
            wr(ADDR_RUN_FLAGS, 8'h00);
            rd(t ? ADDR_T1_LOW : ADDR_T0_LOW);
            chk({7'h0, got > 8'd15 && got < 8'd30}, 8'h01);
        end
        for (int t = 0; t < 2; t++) begin
            setup(t ? 8'h51 : 8'h15, 8'h0C, t, 8'h00, 8'h00);
            wr(ADDR_RUN_FLAGS, t ? 8'h40 : 8'h10);
            falls[t] = 0;
            ev_go[t] = 1'b1;
            repeat (60) @(posedge clk);
            #1 ev_go = 2'b00;
            repeat (12) @(posedge clk);
            wr(ADDR_RUN_FLAGS, 8'h00);
            rd(t ? ADDR_T1_LOW : ADDR_T0_LOW);
            chk(got, 8'(falls[t]));
        end
        irq_en = 1'b1;
        for (int i = 0; i < 3; i++) begin
            setup(8'h33, 8'h0C, 1, sp[i][3], sp[i][2]);
            wr(ADDR_T0_LOW, 8'hFE);
            wr(ADDR_T0_HIGH, sp[i][1]);
            ovf_seen = 0;
            wr(ADDR_MODE_SELECT, sp[i][0]);
            wr(ADDR_RUN_FLAGS, 8'h40);
            repeat (2) @(posedge clk);
            rd(ADDR_RUN_FLAGS);
            chk(got, sp[i][4]);
            chk({7'h0, irq1}, {7'h0, sp[i][4][RUN_TF1]});
            wr(ADDR_RUN_FLAGS, 8'h00);
            rd(ADDR_T0_HIGH);
            chk(got, sp[i][5]);
            rd(ADDR_T0_LOW);
            chk(got, 8'hFE);
            chk(8'(ovf_seen), sp[i][6]);
            rd(ADDR_T1_LOW);
            if (i == 2)
                chk(got, 8'h00);
        end
        close_out();
    end
endmodule
